// ---- pchr_config_header.sv ----
// Configuration header dwords 08h to 1Ch: class code, header bytes and the four base words.
`default_nettype none

module pchr_config_header #(
	parameter logic [7:0] SILICON_REVISION = 8'h5A // Arbitrary neutral revision value.
) (
	input wire logic clk, // Core clock, 250 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire pchr_pkg::pchr_cfg_req_type cfg_req, // Configuration request, one cycle.
	output pchr_pkg::pchr_cfg_rsp_type cfg_rsp, // Completion, one cycle later.
	output logic [63:0] ctrl_window_base, // Base of the 64 kB control window.
	output logic [63:0] msix_window_base, // Base of the MSI-X table window.
	output logic [7:0] cache_line_size // Cache line size as last written.
);

	// ==========================================================================
	// Request decode.
	logic hit_class_rev;
	logic hit_cache_dword;
	logic hit_ctrl_lo;
	logic hit_ctrl_hi;
	logic hit_msix_lo;
	logic hit_msix_hi;
	logic is_write;

	assign is_write = cfg_req.valid && cfg_req.write;
	assign hit_class_rev = cfg_req.dword_index == pchr_pkg::PCHR_OFF_CLASS_REV[11:2];
	assign hit_cache_dword = cfg_req.dword_index == pchr_pkg::PCHR_OFF_CACHE_LINE[11:2];
	assign hit_ctrl_lo = cfg_req.dword_index == pchr_pkg::PCHR_OFF_CTRL_BASE_LO[11:2];
	assign hit_ctrl_hi = cfg_req.dword_index == pchr_pkg::PCHR_OFF_CTRL_BASE_HI[11:2];
	assign hit_msix_lo = cfg_req.dword_index == pchr_pkg::PCHR_OFF_MSIX_BASE_LO[11:2];
	assign hit_msix_hi = cfg_req.dword_index == pchr_pkg::PCHR_OFF_MSIX_BASE_HI[11:2];

	// ==========================================================================
	// Fixed words.
	// The class word has no storage at all, so a write to it cannot land anywhere.
	logic [31:0] class_rev_word;

	assign class_rev_word = {
		pchr_pkg::PCHR_BASE_CLASS_CODE,
		pchr_pkg::PCHR_SUB_CLASS_CODE,
		pchr_pkg::PCHR_PROGRAMMING_INTERFACE_CODE,
		SILICON_REVISION
	};

	// ==========================================================================
	// Cache line size dword.
	// Only the low lane can load; the three upper header bytes are constants in the mask.
	logic [31:0] cache_dword_q;

	pchr_masked_reg #(
		.RESET_VALUE({pchr_pkg::PCHR_SELF_TEST_VALUE, pchr_pkg::PCHR_HEADER_TYPE_VALUE,
			pchr_pkg::PCHR_LATENCY_TIMER_VALUE, pchr_pkg::PCHR_CACHE_LINE_RESET}),
		.WRITE_MASK(pchr_pkg::PCHR_CACHE_LINE_DWORD_MASK)
	) u_cache_dword (
		.clk(clk),
		.rst(rst),
		.wr_en(is_write && hit_cache_dword),
		.byte_en(cfg_req.byte_en),
		.wdata(cfg_req.wdata),
		.value_q(cache_dword_q)
	);

	// ==========================================================================
	// Control register window base pair.
	logic [31:0] ctrl_lo_q;
	logic [31:0] ctrl_hi_q;

	pchr_masked_reg #(
		.RESET_VALUE(pchr_pkg::PCHR_BASE_LO_RESET),
		.WRITE_MASK(pchr_pkg::PCHR_CTRL_BASE_LO_MASK)
	) u_ctrl_lo (
		.clk(clk),
		.rst(rst),
		.wr_en(is_write && hit_ctrl_lo),
		.byte_en(cfg_req.byte_en),
		.wdata(cfg_req.wdata),
		.value_q(ctrl_lo_q)
	);

	pchr_masked_reg #(
		.RESET_VALUE(pchr_pkg::PCHR_BASE_HI_RESET),
		.WRITE_MASK(pchr_pkg::PCHR_BASE_HI_MASK)
	) u_ctrl_hi (
		.clk(clk),
		.rst(rst),
		.wr_en(is_write && hit_ctrl_hi),
		.byte_en(cfg_req.byte_en),
		.wdata(cfg_req.wdata),
		.value_q(ctrl_hi_q)
	);

	// ==========================================================================
	// MSI-X window base pair.
	// Writable bits follow the 31:20 field range, which sizes the window at 1 MB.
	logic [31:0] msix_lo_q;
	logic [31:0] msix_hi_q;

	pchr_masked_reg #(
		.RESET_VALUE(pchr_pkg::PCHR_BASE_LO_RESET),
		.WRITE_MASK(pchr_pkg::PCHR_MSIX_BASE_LO_MASK)
	) u_msix_lo (
		.clk(clk),
		.rst(rst),
		.wr_en(is_write && hit_msix_lo),
		.byte_en(cfg_req.byte_en),
		.wdata(cfg_req.wdata),
		.value_q(msix_lo_q)
	);

	pchr_masked_reg #(
		.RESET_VALUE(pchr_pkg::PCHR_BASE_HI_RESET),
		.WRITE_MASK(pchr_pkg::PCHR_BASE_HI_MASK)
	) u_msix_hi (
		.clk(clk),
		.rst(rst),
		.wr_en(is_write && hit_msix_hi),
		.byte_en(cfg_req.byte_en),
		.wdata(cfg_req.wdata),
		.value_q(msix_hi_q)
	);

	// ==========================================================================
	// Read data selection.
	// Attribute bits 3:0 of the low bases are masked-off constants (0100b), so
	// memory space, 64-bit placement and no prefetch read back the same whatever is written.
	logic [31:0] read_word_d;
	logic claimed_d;

	always_comb begin
		read_word_d = 32'h0000_0000;
		claimed_d = 1'b1;
		case (1'b1)
			hit_class_rev: begin
				read_word_d = class_rev_word;
			end
			hit_cache_dword: begin
				read_word_d = cache_dword_q;
			end
			hit_ctrl_lo: begin
				read_word_d = ctrl_lo_q;
			end
			hit_ctrl_hi: begin
				read_word_d = ctrl_hi_q;
			end
			hit_msix_lo: begin
				read_word_d = msix_lo_q;
			end
			hit_msix_hi: begin
				read_word_d = msix_hi_q;
			end
			default: begin
				claimed_d = 1'b0;
			end
		endcase
	end

	// ==========================================================================
	// Completion.
	// Every request, read or write, to a claimed dword completes one cycle later;
	// writes that touch only read-only bits complete the same way.
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_rsp <= '0;
		end else begin
			cfg_rsp.valid <= cfg_req.valid;
			cfg_rsp.claimed <= cfg_req.valid && claimed_d;
			cfg_rsp.rdata <= (cfg_req.valid && !cfg_req.write) ? read_word_d : 32'h0000_0000;
		end
	end

	// ==========================================================================
	// Window bases for the address decoder.
	// Registered copies keep the outputs on flops and ease timing into the decoder.
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_window_base <= 64'h0000_0000_0000_0000;
			msix_window_base <= 64'h0000_0000_0000_0000;
			cache_line_size <= pchr_pkg::PCHR_CACHE_LINE_RESET;
		end else begin
			ctrl_window_base <= {ctrl_hi_q, ctrl_lo_q & ~pchr_pkg::PCHR_BASE_LO_ATTR_MASK};
			msix_window_base <= {msix_hi_q, msix_lo_q & ~pchr_pkg::PCHR_BASE_LO_ATTR_MASK};
			cache_line_size <= cache_dword_q[7:0];
		end
	end

endmodule // pchr_config_header

`default_nettype wire

// ---- pchr_hdr_props.sv ----
// Checker of the configuration header block, seen from its ports.
`default_nettype none

module pchr_hdr_props #(
	parameter logic [7:0] SILICON_REVISION = 8'h5A
) (
	input wire logic clk, // Core clock.
	input wire logic rst, // Synchronous reset.
	input wire pchr_pkg::pchr_cfg_req_type cfg_req, // Request watched.
	input wire pchr_pkg::pchr_cfg_rsp_type cfg_rsp, // Completion watched.
	input wire logic [63:0] ctrl_window_base, // Control window base.
	input wire logic [63:0] msix_window_base, // MSI-X window base.
	input wire logic [7:0] cache_line_size // Cache line size byte.
);
	// ==========================================================================
	// Assertions.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic rd = cfg_req.valid && !cfg_req.write;
	wire logic [9:0] ix = cfg_req.dword_index;
	wire logic wf = cfg_req.valid && cfg_req.write && cfg_req.byte_en == 4'hF;
	chk_rsp_follows: assert property (cfg_req.valid |=> cfg_rsp.valid)
		else $error("Request left without completion.");
	chk_rsp_alone: assert property (!cfg_req.valid |=> !cfg_rsp.valid)
		else $error("Completion without request.");
	chk_class_word: assert property (rd && ix == 10'h002 |=>
		cfg_rsp.rdata == {8'h0C, 8'h03, 8'h30, SILICON_REVISION}) else $error("Class word wrong.");
	chk_hdr_bytes: assert property (rd && ix == 10'h003 |=> cfg_rsp.rdata[31:8] == 24'h0)
		else $error("Fixed header bytes not zero.");
	chk_base_attr: assert property (rd && (ix == 10'h004 || ix == 10'h006) |=>
		cfg_rsp.rdata[3:0] == 4'h4) else $error("Base attribute bits wrong.");
	chk_ctrl_rsvd: assert property (rd && ix == 10'h004 |=> cfg_rsp.rdata[15:4] == 12'h0)
		else $error("Control base reserved bits set.");
	chk_msix_rsvd: assert property (rd && ix == 10'h006 |=> cfg_rsp.rdata[19:4] == 16'h0)
		else $error("MSI-X base reserved bits set.");
	chk_unmapped_dword: assert property (cfg_req.valid && !(ix inside {[2:7]}) |=>
		!cfg_rsp.claimed && cfg_rsp.rdata == 32'h0) else $error("Foreign dword claimed.");
	chk_ctrl_high: assert property (wf && ix == 10'h005 |->
		##2 ctrl_window_base[63:32] == $past(cfg_req.wdata, 2)) else $error("Control high lost.");
	chk_msix_low: assert property (wf && ix == 10'h006 |->
		##2 msix_window_base[31:20] == $past(cfg_req.wdata[31:20], 2)) else $error("MSI-X low lost.");
	chk_ctrl_low: assert property (wf && ix == 10'h004 |->
		##2 ctrl_window_base[31:16] == $past(cfg_req.wdata[31:16], 2)
		&& ctrl_window_base[15:0] == 16'h0) else $error("Control low wrong.");
	chk_msix_high: assert property (wf && ix == 10'h007 |->
		##2 msix_window_base[63:32] == $past(cfg_req.wdata, 2)) else $error("MSI-X high lost.");
	chk_cache_line: assert property (cfg_req.valid && cfg_req.write && cfg_req.byte_en[0]
		&& ix == 10'h003 |-> ##2 cache_line_size == $past(cfg_req.wdata[7:0], 2))
		else $error("Cache line size lost.");
endmodule // pchr_hdr_props

bind pchr_config_header pchr_hdr_props #(.SILICON_REVISION(SILICON_REVISION)) u_props (.clk(clk),
	.rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .ctrl_window_base(ctrl_window_base),
	.msix_window_base(msix_window_base), .cache_line_size(cache_line_size));

`default_nettype wire

// ---- pchr_masked_reg.sv ----
// One configuration dword with per-bit write mask and byte enables.
`default_nettype none

module pchr_masked_reg #(
	parameter logic [31:0] RESET_VALUE = 32'h0000_0000,
	parameter logic [31:0] WRITE_MASK = 32'h0000_0000
) (
	input wire logic clk, // Core clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic wr_en, // Write strobe for this dword.
	input wire logic [3:0] byte_en, // Byte lanes being written.
	input wire logic [31:0] wdata, // Write data.
	output logic [31:0] value_q // Current register contents.
);

	// ==========================================================================
	// Storage, one lane per byte.
	// Read-only bits never load, so they hold their reset constant for good.
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			always_ff @(posedge clk) begin
				if (rst) begin
					value_q[lane*8 +: 8] <= RESET_VALUE[lane*8 +: 8];
				end else if (wr_en && byte_en[lane]) begin
					value_q[lane*8 +: 8] <= (wdata[lane*8 +: 8] & WRITE_MASK[lane*8 +: 8])
						| (value_q[lane*8 +: 8] & ~WRITE_MASK[lane*8 +: 8]);
				end
			end
		end
	endgenerate

endmodule // pchr_masked_reg

`default_nettype wire

// ---- pchr_pkg.sv ----
// Constants and carrier types shared by the configuration header register block.
`default_nettype none

package pchr_pkg;

	// ==========================================================================
	// Configuration offsets (byte offsets within configuration space).
	localparam logic [11:0] PCHR_OFF_CLASS_REV = 12'h008;
	localparam logic [11:0] PCHR_OFF_CACHE_LINE = 12'h00C;
	localparam logic [11:0] PCHR_OFF_LATENCY_TIMER = 12'h00D;
	localparam logic [11:0] PCHR_OFF_HEADER_TYPE = 12'h00E;
	localparam logic [11:0] PCHR_OFF_SELF_TEST = 12'h00F;
	localparam logic [11:0] PCHR_OFF_CTRL_BASE_LO = 12'h010;
	localparam logic [11:0] PCHR_OFF_CTRL_BASE_HI = 12'h014;
	localparam logic [11:0] PCHR_OFF_MSIX_BASE_LO = 12'h018;
	localparam logic [11:0] PCHR_OFF_MSIX_BASE_HI = 12'h01C;

	// ==========================================================================
	// Fixed identification fields.
	localparam logic [7:0] PCHR_BASE_CLASS_CODE = 8'h0C;
	localparam logic [7:0] PCHR_SUB_CLASS_CODE = 8'h03;
	localparam logic [7:0] PCHR_PROGRAMMING_INTERFACE_CODE = 8'h30;
	localparam logic [7:0] PCHR_LATENCY_TIMER_VALUE = 8'h00;
	localparam logic [7:0] PCHR_HEADER_TYPE_VALUE = 8'h00;
	localparam logic [7:0] PCHR_SELF_TEST_VALUE = 8'h00;

	// ==========================================================================
	// Reset values.
	localparam logic [7:0] PCHR_CACHE_LINE_RESET = 8'h00;
	localparam logic [31:0] PCHR_BASE_LO_RESET = 32'h0000_0004;
	localparam logic [31:0] PCHR_BASE_HI_RESET = 32'h0000_0000;

	// ==========================================================================
	// Writable bit masks; every other bit keeps its reset value.
	localparam logic [31:0] PCHR_CACHE_LINE_DWORD_MASK = 32'h0000_00FF;
	localparam logic [31:0] PCHR_CTRL_BASE_LO_MASK = 32'hFFFF_0000;
	localparam logic [31:0] PCHR_MSIX_BASE_LO_MASK = 32'hFFF0_0000;
	localparam logic [31:0] PCHR_BASE_HI_MASK = 32'hFFFF_FFFF;

	// ==========================================================================
	// Field positions of the lower base address words.
	localparam int PCHR_MEMORY_SPACE_INDICATOR_BIT = 0;
	localparam int PCHR_PREFETCH_BIT = 3;
	localparam logic [31:0] PCHR_BASE_LO_ATTR_MASK = 32'h0000_000F;

	// ==========================================================================
	// Configuration request and completion carriers.
	typedef struct packed {
		logic valid;
		logic write;
		logic [9:0] dword_index;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} pchr_cfg_req_type;

	typedef struct packed {
		logic valid;
		logic claimed;
		logic [31:0] rdata;
	} pchr_cfg_rsp_type;

endpackage

`default_nettype wire

// ---- pchr_rc_model.sv ----
// Root complex model that issues configuration requests one at a time.
`default_nettype none

module pchr_rc_model (
	input wire logic clk, // Core clock.
	output pchr_pkg::pchr_cfg_req_type cfg_req, // Request to the header block.
	input wire pchr_pkg::pchr_cfg_rsp_type cfg_rsp // Completion from the header block.
);
	timeunit 1ns;
	timeprecision 1ps;
	initial cfg_req = '0;
	// ==========================================================================
	// Released fields are inverted so that stale values never pass for a live request.
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [3:0] b,
		input logic [31:0] d, output pchr_pkg::pchr_cfg_rsp_type rsp);
		@(posedge clk);
		cfg_req <= {1'b1, wr, a, b, d};
		@(posedge clk);
		cfg_req <= {1'b0, ~wr, ~a, ~b, ~d};
		@(posedge clk);
		rsp = cfg_rsp;
	endtask
endmodule // pchr_rc_model

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench of the configuration header block.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] REV = 8'hA7; // Arbitrary revision value.
	logic clk;
	logic rst;
	pchr_pkg::pchr_cfg_req_type cfg_req;
	pchr_pkg::pchr_cfg_rsp_type cfg_rsp;
	pchr_pkg::pchr_cfg_rsp_type rsp;
	logic [63:0] ctrl_window_base;
	logic [63:0] msix_window_base;
	logic [7:0] cache_line_size;
	logic [31:0] shadow [0:7];
	int error_cnt;
	int n_compared;
	int seed;
	int i;
	pchr_config_header #(.SILICON_REVISION(REV)) DUT (.clk(clk), .rst(rst), .cfg_req(cfg_req),
		.cfg_rsp(cfg_rsp), .ctrl_window_base(ctrl_window_base),
		.msix_window_base(msix_window_base), .cache_line_size(cache_line_size));
	pchr_rc_model rc (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========================================================================
	// Expectations and checks.
	function automatic logic [31:0] wmask(input logic [9:0] a);
		case (a)
			10'h003: wmask = 32'h0000_00FF;
			10'h004: wmask = 32'hFFFF_0000;
			10'h005, 10'h007: wmask = 32'hFFFF_FFFF;
			10'h006: wmask = 32'hFFF0_0000;
			default: wmask = 32'h0000_0000;
		endcase
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	task automatic access(input logic wr, input logic [9:0] a, input logic [3:0] b,
		input logic [31:0] d);
		logic [31:0] m;
		logic [31:0] exp;
		m = wmask(a) & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		exp = (a == 10'h002) ? {8'h0C, 8'h03, 8'h30, REV} : (a inside {[3:7]}) ? shadow[a] : 0;
		rc.xfer(wr, a, b, d, rsp);
		check(64'({rsp.valid, rsp.claimed}), 64'({1'b1, a inside {[2:7]}}),
			"completion flags");
		check(64'(rsp.rdata), 64'(wr ? 32'h0 : exp), "read data");
		if (wr && a inside {[3:7]})
			shadow[a] = (shadow[a] & ~m) | (d & m);
		if (!wr) begin
			check(ctrl_window_base, {shadow[5], shadow[4][31:4], 4'h0}, "ctrl base");
			check(msix_window_base, {shadow[7], shadow[6][31:4], 4'h0}, "msix base");
			check(64'(cache_line_size), 64'(shadow[3][7:0]), "cache line");
		end
	endtask
	// Reset is repeated mid-run, so the shadow copy is rebuilt each time.
	task automatic reset_dut();
		rst <= 1'b1;
		for (int k = 0; k < 8; k++)
			shadow[k] = (k == 4 || k == 6) ? 32'h0000_0004 : 32'h0000_0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int k = 0; k < 10; k++)
			access(1'b0, 10'(k), 4'hF, 32'h0);
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================================================
	// Main sequence.
	initial begin
		rst = 1'b1;
		seed = 389;
		error_cnt = 0;
		n_compared = 0;
		reset_dut();
		for (i = 2; i < 8; i++) begin
			access(1'b1, 10'(i), 4'hF, 32'hFFFF_FFFF);
			access(1'b0, 10'(i), 4'hF, 32'h0);
		end
		for (i = 0; i < 80; i++) begin
			access(1'b1, 10'({$random(seed)} % 10), 4'($random(seed)), $random(seed));
			access(1'b0, 10'({$random(seed)} % 10), 4'hF, 32'h0);
			if (i == 40)
				reset_dut();
		end
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule // tb_top

`default_nettype wire
